// file: bbc_pkg.sv
// Package with register map, field layout and reset values of the bridge config block
package bbc_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFS_ISSUE_LIMIT = 12'h008;
    localparam logic [11:0] OFS_CROSS_SEL = 12'h020;
    localparam logic [11:0] OFS_MERGE_BYP = 12'h024;
    localparam logic [11:0] OFS_LONG_BURST = 12'h02C;
    localparam int unsigned ISSUE_W = 2;
    localparam int unsigned CROSS_W = 3;
    localparam int unsigned ISSUE_RD_BIT = 0;
    localparam int unsigned ISSUE_WR_BIT = 1;
    localparam logic [1:0] RST_ISSUE_LIMIT = 2'h0;
    localparam logic [2:0] RST_CROSS_SEL = 3'h4;
    localparam logic RST_MERGE_BYP = 1'b0;
    localparam logic RST_LONG_BURST = 1'b0;
    localparam logic [2:0] CROSS_SYNC_1_1 = 3'h0;
    localparam logic [2:0] CROSS_SYNC_M_1 = 3'h1;
    localparam logic [2:0] CROSS_SYNC_1_N = 3'h2;
    localparam logic [2:0] CROSS_SYNC_M_N = 3'h3;
    localparam logic [2:0] CROSS_ASYNC = 3'h4;
    localparam int unsigned REG_CNT = 4;
    localparam logic [1:0] IDX_ISSUE = 2'h0;
    localparam logic [1:0] IDX_CROSS = 2'h1;
    localparam logic [1:0] IDX_MERGE = 2'h2;
    localparam logic [1:0] IDX_LONG = 2'h3;
endpackage

// file: bbc_field_reg.sv
// One resettable, writable configuration field with optional presence
`timescale 1ns/1ps
`default_nettype none
module bbc_field_reg #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0,
    parameter bit PRESENT = 1'b1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] value
);
    logic [WIDTH-1:0] value_ff;

    // Absent field holds its reset value forever
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            value_ff <= RESET_VAL;
        end else if (PRESENT && wr_en) begin
            value_ff <= wr_data;
        end
    end

    assign value = value_ff;
endmodule
`default_nettype wire

// file: bbc_bridge_cfg.sv
// APB register bank holding the bridge block configuration settings
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Issue-limit register is two bits, resets to zero, set bit limits to one outstanding
// - Bit 0 set limits the preceding switch to one outstanding read
// - Bit 1 set limits the preceding switch to one outstanding write
// - Three-bit crossing selector: 0..3 sync variants, 4 async; 5..7 reserved
// - Crossing selector exists only when programmable; resets to async value 4
// - One-bit merge bypass, reset zero, exists only when width converting
// - Long-burst permit zero (reset) means long bursts are broken up
// - Long-burst permit one allows long bursts at the output
// - Long-burst permit exists only when downsizing to AXI4; else stays zero
module bbc_bridge_cfg #(
    parameter bit HAS_ISSUE_LIMIT = 1'b1,
    parameter bit HAS_CROSS_SEL = 1'b1,
    parameter bit HAS_MERGE_BYP = 1'b1,
    parameter bit HAS_LONG_BURST = 1'b1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    output logic read_issue_single,
    output logic write_issue_single,
    output logic [2:0] clock_crossing_mode,
    output logic merge_bypass,
    output logic long_burst_allow
);
    localparam int unsigned REG_CNT_L = bbc_pkg::REG_CNT;
    logic [REG_CNT_L-1:0] wr_sel;
    logic [1:0] issue_val;
    logic [2:0] cross_val;
    logic merge_val;
    logic long_val;
    logic [31:0] nxt_rdata;
    logic [31:0] prdata_ff;
    logic wr_access;
    logic byte0_en;

    // Address decode to register index; bit 4 marks a hit
    function automatic logic [4:0] decode(input logic [11:0] addr);
        logic [4:0] hit;
        hit = 5'h00;
        case (addr)
            bbc_pkg::OFS_ISSUE_LIMIT: hit = {HAS_ISSUE_LIMIT, 2'h0, bbc_pkg::IDX_ISSUE};
            bbc_pkg::OFS_CROSS_SEL: hit = {HAS_CROSS_SEL, 2'h0, bbc_pkg::IDX_CROSS};
            bbc_pkg::OFS_MERGE_BYP: hit = {HAS_MERGE_BYP, 2'h0, bbc_pkg::IDX_MERGE};
            bbc_pkg::OFS_LONG_BURST: hit = {HAS_LONG_BURST, 2'h0, bbc_pkg::IDX_LONG};
            default: hit = 5'h00;
        endcase
        return hit;
    endfunction

    // Zero-wait slave; unmapped addresses complete without error
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_access = psel && penable && pwrite;
    assign byte0_en = pstrb[0];

    // Writes only reach a decoded, present register with lane 0 enabled
    always_comb begin
        logic [4:0] hit;
        hit = decode(paddr);
        wr_sel = '0;
        if (wr_access && byte0_en && hit[4]) begin
            wr_sel[hit[1:0]] = 1'b1;
        end
    end

    bbc_field_reg #(
        .WIDTH(bbc_pkg::ISSUE_W),
        .RESET_VAL(bbc_pkg::RST_ISSUE_LIMIT),
        .PRESENT(HAS_ISSUE_LIMIT)
    ) u_issue (
        .clock(clock),
        .resetn(resetn),
        .wr_en(wr_sel[bbc_pkg::IDX_ISSUE]),
        .wr_data(pwdata[1:0]),
        .value(issue_val)
    );

    bbc_field_reg #(
        .WIDTH(bbc_pkg::CROSS_W),
        .RESET_VAL(bbc_pkg::RST_CROSS_SEL),
        .PRESENT(HAS_CROSS_SEL)
    ) u_cross (
        .clock(clock),
        .resetn(resetn),
        .wr_en(wr_sel[bbc_pkg::IDX_CROSS]),
        .wr_data(pwdata[2:0]),
        .value(cross_val)
    );

    bbc_field_reg #(
        .WIDTH(1),
        .RESET_VAL(bbc_pkg::RST_MERGE_BYP),
        .PRESENT(HAS_MERGE_BYP)
    ) u_merge (
        .clock(clock),
        .resetn(resetn),
        .wr_en(wr_sel[bbc_pkg::IDX_MERGE]),
        .wr_data(pwdata[0]),
        .value(merge_val)
    );

    bbc_field_reg #(
        .WIDTH(1),
        .RESET_VAL(bbc_pkg::RST_LONG_BURST),
        .PRESENT(HAS_LONG_BURST)
    ) u_long (
        .clock(clock),
        .resetn(resetn),
        .wr_en(wr_sel[bbc_pkg::IDX_LONG]),
        .wr_data(pwdata[0]),
        .value(long_val)
    );

    // Settings presented to the datapath
    assign read_issue_single = issue_val[bbc_pkg::ISSUE_RD_BIT];
    assign write_issue_single = issue_val[bbc_pkg::ISSUE_WR_BIT];
    assign clock_crossing_mode = cross_val;
    assign merge_bypass = merge_val;
    assign long_burst_allow = long_val;

    // Read mux; absent or reserved locations read zero
    always_comb begin
        logic [4:0] hit;
        hit = decode(paddr);
        nxt_rdata = 32'h0000_0000;
        if (hit[4]) begin
            case (hit[1:0])
                bbc_pkg::IDX_ISSUE: nxt_rdata = {30'h0, issue_val};
                bbc_pkg::IDX_CROSS: nxt_rdata = {29'h0, cross_val};
                bbc_pkg::IDX_MERGE: nxt_rdata = {31'h0, merge_val};
                bbc_pkg::IDX_LONG: nxt_rdata = {31'h0, long_val};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Read data registered in the setup cycle, stable through the access phase
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= nxt_rdata;
        end
    end

    assign prdata = prdata_ff;
endmodule
`default_nettype wire

// file: bbc_chk_assertions.sv
// Checker with concurrent assertions for the bridge config registers
`timescale 1ns/1ps
`default_nettype none
module bbc_chk (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic read_issue_single,
    input wire logic write_issue_single,
    input wire logic [2:0] clock_crossing_mode,
    input wire logic merge_bypass,
    input wire logic long_burst_allow
);
    wire logic wr = psel && penable && pwrite && pstrb[0];
    wire logic rs = psel && !penable && !pwrite;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    issue_rd_a: assert property (wr && paddr == 12'h008
        |=> read_issue_single == $past(pwdata[0])) else $error("read limit wrong");
    issue_wr_a: assert property (wr && paddr == 12'h008
        |=> write_issue_single == $past(pwdata[1])) else $error("write limit wrong");
    cross_wr_a: assert property (wr && paddr == 12'h020
        |=> clock_crossing_mode == $past(pwdata[2:0])) else $error("crossing wrong");
    burst_wr_a: assert property (wr && paddr == 12'h02C
        |=> long_burst_allow == $past(pwdata[0])) else $error("burst permit wrong");
    hold_cfg_a: assert property (!wr |=> $stable({read_issue_single,
        write_issue_single, clock_crossing_mode, merge_bypass, long_burst_allow}))
        else $error("setting moved without write");
    issue_rb_a: assert property (rs && paddr == 12'h008
        |=> prdata == {30'h0, write_issue_single, read_issue_single}) else $error("rd 008");
    cross_rb_a: assert property (rs && paddr == 12'h020
        |=> prdata == {29'h0, clock_crossing_mode}) else $error("rd 020");
    rsvd_rb_a: assert property (rs && paddr == 12'h028
        |=> prdata == 32'h0) else $error("reserved read not zero");
    cover property (wr && paddr == 12'h020);
    cover property (wr && paddr == 12'h02C);
    cover property (rs && paddr == 12'h028);
endmodule
bind bbc_bridge_cfg bbc_chk bbc_chk_inst (.*);
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the bridge config register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, r;
    logic [3:0] pstrb = 4'hF;
    wire logic pready, pslverr, read_issue_single, write_issue_single;
    wire logic merge_bypass, long_burst_allow;
    wire logic [2:0] clock_crossing_mode;
    wire logic [31:0] prdata;
    logic [31:0] e [4] = '{32'h0, 32'h4, 32'h0, 32'h0};
    logic [11:0] ad [4] = '{12'h008, 12'h020, 12'h024, 12'h02C};
    logic [11:0] rv [6] = '{12'h000, 12'h004, 12'h00C, 12'h028, 12'h030, 12'hFFC};
    int n_fail = 0, checks_done = 0, cyc = 0;
    bbc_bridge_cfg bbc_bridge_cfg_inst (
        .clock(clock),
        .resetn(resetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .pready(pready),
        .pslverr(pslverr),
        .prdata(prdata),
        .read_issue_single(read_issue_single),
        .write_issue_single(write_issue_single),
        .clock_crossing_mode(clock_crossing_mode),
        .merge_bypass(merge_bypass),
        .long_burst_allow(long_burst_allow)
    );
    always #5 clock = ~clock;
    task chk(input logic [31:0] s, input logic [31:0] x);
        checks_done++;
        if (s !== x) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task cmp_all;
        @(negedge clock);
        chk({30'h0, write_issue_single, read_issue_single}, e[0]);
        chk({29'h0, clock_crossing_mode}, e[1]);
        chk({31'h0, merge_bypass}, e[2]);
        chk({31'h0, long_burst_allow}, e[3]);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, ad[i], 32'h0);
            chk(r, e[i]);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input int i, input logic [31:0] x);
        xfer(1'b1, a, d);
        e[i] = x;
        cmp_all;
    endtask
    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        cmp_all;
        $display("reset test done");
        for (int v = 0; v < 4; v++) wr(12'h008, 32'hFFFF_FFFC | 32'(v), 0, 32'(v));
        for (int v = 0; v < 5; v++) wr(12'h020, 32'(v), 1, 32'(v));
        wr(12'h024, 32'h1, 2, 32'h1);
        wr(12'h02C, 32'h1, 3, 32'h1);
        $display("field test done");
        pstrb <= 4'hE;
        xfer(1'b1, 12'h024, 32'h0);
        pstrb <= 4'hF;
        @(negedge clock);
        chk({31'h0, merge_bypass}, 32'h1);
        chk(32'(pslverr), 32'h0);
        $display("strobe test done");
        foreach (rv[i]) begin
            xfer(1'b1, rv[i], 32'hFFFF_FFFF);
            xfer(1'b0, rv[i], 32'h0);
            chk(r, 32'h0);
        end
        cmp_all;
        $display("reserved test done");
        summarize;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            summarize;
        end
    end
    task summarize;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
endmodule
`default_nettype wire
